//--- pmcd_core.sv
// page map control datapath: counters, error capture, modes, address paths
`timescale 1ns/1ps
`include "pmcd_defines.svh"
module pmcd_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] io_bus,
  input wire logic io_write_strobe_n,
  input wire logic translation_inhibit_n,
  input wire logic memory_pointer_load_n,
  input wire logic memory_pointer_step,
  input wire logic transfer_fault_strobe,
  input wire logic cpu_full_clock,
  input wire logic system_reset_line_n,
  input wire logic [3:0] selected_key,
  input wire logic predecode_phase,
  input wire logic error_detected,
  input wire logic external_control_instruction,
  input wire logic [2:0] control_function,
  input wire logic jump_decoded,
  input wire pmcd_pkg::pmcd_entry_t map_entry,
  input wire logic [15:0] logical_address,
  input wire logic memory_request,
  input wire logic instruction_fetch,
  input wire logic write_access,
  input wire logic [17:0] expansion_data_1,
  input wire logic [17:0] expansion_data_2,
  input wire logic [17:0] expansion_data_3,
  input wire logic data_driver_enable,
  output logic [9:0] map_entry_pointer,
  output logic [1:0] read_source_select,
  output logic transfer_outbound,
  output logic transfer_inbound,
  output logic [15:0] transfer_memory_pointer,
  output logic [15:0] io_read_data,
  output logic translation_active,
  output logic user_control,
  output logic executive_control,
  output logic protection_on,
  output pmcd_pkg::pmcd_access_t page_access,
  output logic access_refused,
  output logic unmapped_strobe,
  output logic page_dirty_bit,
  output logic page_used_bit,
  output logic [15:0] expansion_address_1,
  output logic [15:0] expansion_address_2,
  output logic [15:0] expansion_address_3,
  output logic [6:0] port_page,
  output logic mainframe_request,
  output logic [17:0] memory_data
);
  function automatic pmcd_pkg::pmcd_access_t decode_access(
    input logic [1:0] acc
  );
    pmcd_pkg::pmcd_access_t d;
    d.unassigned = (acc == `PMCD_ACC_UNASSIGNED);
    d.full_access = (acc == `PMCD_ACC_FULL);
    d.operand_only = (acc == `PMCD_ACC_OPERAND);
    d.read_only = (acc == `PMCD_ACC_READ_ONLY);
    return d;
  endfunction

  // pin synchronisers: bit 0 write strobe_n, 1 inhibit_n, 2 pointer load_n,
  // 3 pointer step, 4 fault strobe, 5 full clock, 6 system reset_n
  logic [6:0] pins;
  logic [6:0] s1_ff;
  logic [6:0] s2_ff;
  logic [6:0] s3_ff;
  logic [6:0] lvl_ff;
  logic [6:0] rise;
  logic [6:0] fall;

  assign pins = {system_reset_line_n, cpu_full_clock, transfer_fault_strobe,
                 memory_pointer_step, memory_pointer_load_n,
                 translation_inhibit_n, io_write_strobe_n};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_ff <= `PMCD_PIN_IDLE;
      s2_ff <= `PMCD_PIN_IDLE;
      s3_ff <= `PMCD_PIN_IDLE;
    end else if (ce) begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // filtered level only moves once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lvl_ff <= `PMCD_PIN_IDLE;
    end else if (ce) begin
      lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
    end
  end

  assign rise = s2_ff & s3_ff & ~lvl_ff;
  assign fall = ~s2_ff & ~s3_ff & lvl_ff;

  // the bus is sampled only under a strobe, so it is taken to be settled
  // by the time the filtered strobe edge is seen
  logic [9:0] ptr_ff;
  logic [1:0] sel_ff;
  logic dir_ff;
  logic [15:0] mptr_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_ff <= 10'h000;
    end else if (ce) begin
      if (!lvl_ff[0]) begin
        ptr_ff <= io_bus[`PMCD_PTR_MSB:0];
      end else if (rise[1]) begin
        ptr_ff <= ptr_ff + 10'h001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_ff <= `PMCD_SRC_STATUS;
      dir_ff <= 1'b0;
    end else if (ce && fall[0]) begin
      sel_ff <= io_bus[`PMCD_SEL_MSB:`PMCD_SEL_LSB];
      dir_ff <= io_bus[`PMCD_DIR_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mptr_ff <= 16'h0000;
    end else if (ce) begin
      if (!lvl_ff[2]) begin
        mptr_ff <= io_bus;
      end else if (rise[3]) begin
        mptr_ff <= mptr_ff + 16'h0001;
      end
    end
  end

  // instruction decode: sequencer and protection codes act at once,
  // mode codes wait for the following jump
  logic code_go;
  logic go_ff;
  logic prot_ff;
  logic frozen_ff;
  logic pend_ff;
  logic [2:0] pend_fn_ff;
  logic active_ff;
  logic user_ff;

  assign code_go = ce && external_control_instruction;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      go_ff <= 1'b0;
    end else if (code_go) begin
      if (control_function == `PMCD_FN_DMA_START) begin
        go_ff <= 1'b1;
      end else if (control_function == `PMCD_FN_DMA_RESET) begin
        go_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prot_ff <= 1'b0;
    end else if (code_go) begin
      if (control_function == `PMCD_FN_PROT_ON) begin
        prot_ff <= 1'b1;
      end else if (control_function == `PMCD_FN_PROT_OFF) begin
        prot_ff <= 1'b0;
      end
    end
  end

  // a new error wins over a protection re-enable in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      frozen_ff <= 1'b0;
    end else if (ce) begin
      if (error_detected) begin
        frozen_ff <= 1'b1;
      end else if (code_go && control_function == `PMCD_FN_PROT_ON) begin
        frozen_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_ff <= 1'b0;
      pend_fn_ff <= `PMCD_FN_INACTIVE;
    end else if (ce) begin
      if (code_go && control_function <= `PMCD_FN_USER) begin
        pend_ff <= 1'b1;
        pend_fn_ff <= control_function;
      end else if (jump_decoded) begin
        pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      active_ff <= 1'b0;
    end else if (ce) begin
      if (!lvl_ff[6]) begin
        active_ff <= 1'b0;
      end else if (pend_ff && jump_decoded) begin
        if (pend_fn_ff == `PMCD_FN_ACTIVATE) begin
          active_ff <= 1'b1;
        end else if (pend_fn_ff == `PMCD_FN_INACTIVE) begin
          active_ff <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      user_ff <= 1'b0;
    end else if (ce && pend_ff && jump_decoded) begin
      if (pend_fn_ff == `PMCD_FN_USER) begin
        user_ff <= 1'b1;
      end else if (pend_fn_ff == `PMCD_FN_ACTIVATE) begin
        user_ff <= 1'b0;
      end
    end
  end

  // error capture
  logic [3:0] fkey_ff;
  logic [15:0] iaddr_ff;
  logic [15:0] uaddr_ff;
  logic ia_load;
  logic ua_load;
  pmcd_pkg::pmcd_access_t acc_now;

  assign acc_now = decode_access(map_entry.access);
  assign ia_load = ce && rise[5] && predecode_phase && prot_ff && !frozen_ff;
  assign ua_load = ce && memory_request && prot_ff && acc_now.unassigned;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fkey_ff <= 4'h0;
    end else if (ce && rise[4]) begin
      fkey_ff <= selected_key;
    end
  end

  // during predecode the address lines carry the program counter, which
  // already points past the instruction being decoded
  always_ff @(posedge core_clk) begin
    if (rst) begin
      iaddr_ff <= 16'h0000;
    end else if (ia_load) begin
      iaddr_ff <= logical_address;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      uaddr_ff <= 16'h0000;
    end else if (ua_load) begin
      uaddr_ff <= logical_address;
    end
  end

  // registered outputs
  logic out_ff;
  logic in_ff;
  logic [15:0] rdata_ff;
  logic uctl_ff;
  logic ectl_ff;
  pmcd_pkg::pmcd_access_t acc_ff;
  logic refused_ff;
  logic ustb_ff;
  logic dirty_ff;
  logic used_ff;
  logic [15:0] xaddr_ff;
  logic [6:0] ppage_ff;
  logic mreq_ff;
  logic [17:0] mdata_ff;
  logic inhibit;
  logic [17:0] nxt_mdata;

  assign inhibit = !lvl_ff[1];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_ff <= 1'b0;
      in_ff <= 1'b0;
    end else if (ce) begin
      out_ff <= go_ff && dir_ff;
      in_ff <= go_ff && !dir_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else if (ce) begin
      unique case (sel_ff)
        `PMCD_SRC_INSTR: rdata_ff <= iaddr_ff;
        `PMCD_SRC_UNMAP: rdata_ff <= uaddr_ff;
        `PMCD_SRC_STATUS: rdata_ff <= {8'h00, prot_ff, active_ff, user_ff,
                                       dir_ff, fkey_ff};
        default: rdata_ff <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      uctl_ff <= 1'b0;
      ectl_ff <= 1'b0;
    end else if (ce) begin
      uctl_ff <= user_ff && active_ff;
      ectl_ff <= !user_ff && active_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_ff <= '0;
      refused_ff <= 1'b0;
      ustb_ff <= 1'b0;
    end else if (ce) begin
      acc_ff <= acc_now;
      refused_ff <= memory_request && prot_ff &&
                    ((acc_now.operand_only && instruction_fetch) ||
                     (acc_now.read_only && write_access) ||
                     acc_now.unassigned);
      ustb_ff <= ua_load;
    end
  end

  // swapping bits written back into the entry
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dirty_ff <= 1'b0;
      used_ff <= 1'b0;
    end else if (ce) begin
      dirty_ff <= inhibit && io_bus[`PMCD_DIRTY_BIT];
      if (inhibit && out_ff) begin
        used_ff <= !io_bus[`PMCD_USED_BIT];
      end else if (inhibit) begin
        used_ff <= 1'b0;
      end else begin
        used_ff <= memory_request;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      xaddr_ff <= 16'h0000;
      ppage_ff <= 7'h00;
      mreq_ff <= 1'b0;
    end else if (ce) begin
      xaddr_ff <= {map_entry.page, logical_address[8:0]};
      if (active_ff) begin
        ppage_ff <= map_entry.page;
        mreq_ff <= memory_request &&
                   map_entry.mem_sel == `PMCD_SEL_MAINFRAME;
      end else begin
        ppage_ff <= logical_address[15:9];
        mreq_ff <= memory_request;
      end
    end
  end

  // mainframe data never passes through here, so the drivers idle high
  always_comb begin
    nxt_mdata = `PMCD_DATA_IDLE;
    if (data_driver_enable) begin
      unique case (map_entry.mem_sel)
        2'h1: nxt_mdata = expansion_data_1;
        2'h2: nxt_mdata = expansion_data_2;
        2'h3: nxt_mdata = expansion_data_3;
        default: nxt_mdata = `PMCD_DATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mdata_ff <= `PMCD_DATA_IDLE;
    end else if (ce) begin
      mdata_ff <= nxt_mdata;
    end
  end

  assign map_entry_pointer = ptr_ff;
  assign read_source_select = sel_ff;
  assign transfer_outbound = out_ff;
  assign transfer_inbound = in_ff;
  assign transfer_memory_pointer = mptr_ff;
  assign io_read_data = rdata_ff;
  assign translation_active = active_ff;
  assign user_control = uctl_ff;
  assign executive_control = ectl_ff;
  assign protection_on = prot_ff;
  assign page_access = acc_ff;
  assign access_refused = refused_ff;
  assign unmapped_strobe = ustb_ff;
  assign page_dirty_bit = dirty_ff;
  assign page_used_bit = used_ff;
  assign expansion_address_1 = xaddr_ff;
  assign expansion_address_2 = xaddr_ff;
  assign expansion_address_3 = xaddr_ff;
  assign port_page = ppage_ff;
  assign mainframe_request = mreq_ff;
  assign memory_data = mdata_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ptr_load_a: assert property (ce && !lvl_ff[0] |=>
    ptr_ff == $past(io_bus[9:0])) else $error("map pointer load wrong");
  ptr_step_a: assert property (ce && lvl_ff[0] && rise[1] |=>
    ptr_ff == 10'($past(ptr_ff) + 10'h001))
    else $error("map pointer step wrong");
  sel_capture_a: assert property (ce && fall[0] |=>
    sel_ff == $past(io_bus[11:10]) && dir_ff == $past(io_bus[12]))
    else $error("select or direction not captured");
  dir_block_a: assert property (code_go &&
    control_function == `PMCD_FN_DMA_RESET ##1 ce |=>
    !transfer_outbound && !transfer_inbound)
    else $error("direction not blocked after reset code");
  mptr_step_a: assert property (ce && lvl_ff[2] && rise[3] |=>
    mptr_ff == 16'($past(mptr_ff) + 16'h0001))
    else $error("memory pointer step wrong");
  key_capture_a: assert property (ce && rise[4] |=>
    fkey_ff == $past(selected_key)) else $error("fault key not captured");
  ia_freeze_a: assert property (frozen_ff |=> $stable(iaddr_ff))
    else $error("instruction address moved while frozen");
  ua_capture_a: assert property (ua_load |=>
    uaddr_ff == $past(logical_address) && unmapped_strobe)
    else $error("unassigned address not captured");
  active_clear_a: assert property (ce && !lvl_ff[6] |=>
    !translation_active) else $error("system reset left map active");
  mode_excl_a: assert property (!(user_control && executive_control))
    else $error("user and executive both on");
  mainframe_data_a: assert property (ce &&
    map_entry.mem_sel == `PMCD_SEL_MAINFRAME |=> memory_data == 18'h3ffff)
    else $error("mainframe read did not idle drivers");

  load_cover_c: cover property (transfer_outbound && inhibit);
  readback_cover_c: cover property (transfer_inbound && inhibit);
  user_cover_c: cover property (user_control ##1 executive_control);
  unmapped_cover_c: cover property (ua_load);
endmodule

//--- pmcd_defines.svh
// bit positions, instruction function codes and reset values for the map unit
`ifndef PMCD_DEFINES_SVH
`define PMCD_DEFINES_SVH
// io bus field positions
`define PMCD_PTR_MSB 9
`define PMCD_SEL_MSB 11
`define PMCD_SEL_LSB 10
`define PMCD_DIR_BIT 12
`define PMCD_DIRTY_BIT 11
`define PMCD_USED_BIT 12
// read source select encodings
`define PMCD_SRC_STATUS 2'h0
`define PMCD_SRC_INSTR 2'h1
`define PMCD_SRC_UNMAP 2'h2
// access field encodings, bit 10 written before bit 9
`define PMCD_ACC_UNASSIGNED 2'h0
`define PMCD_ACC_FULL 2'h1
`define PMCD_ACC_OPERAND 2'h2
`define PMCD_ACC_READ_ONLY 2'h3
// external control function codes (046, 0146 ... 0746 octal)
`define PMCD_FN_INACTIVE 3'h0
`define PMCD_FN_ACTIVATE 3'h1
`define PMCD_FN_USER 3'h2
`define PMCD_FN_DMA_START 3'h3
`define PMCD_FN_DMA_RESET 3'h4
`define PMCD_FN_PROT_ON 3'h6
`define PMCD_FN_PROT_OFF 3'h7
// memory select value meaning mainframe memory
`define PMCD_SEL_MAINFRAME 2'h0
// pin synchroniser and data driver idle levels, active-low pins idle high
`define PMCD_PIN_IDLE 7'h47
`define PMCD_DATA_IDLE 18'h3ffff
`endif

//--- pmcd_pkg.sv
// types shared by the page map control datapath
package pmcd_pkg;
  typedef struct packed {
    logic used;
    logic dirty;
    logic [1:0] access;
    logic [1:0] mem_sel;
    logic [6:0] page;
  } pmcd_entry_t;

  typedef struct packed {
    logic unassigned;
    logic full_access;
    logic operand_only;
    logic read_only;
  } pmcd_access_t;
endpackage

//--- pmcd_cpu_model.sv
// processor-side model: io bus data and the strobe pins of the map unit
`timescale 1ns/1ps
module pmcd_cpu_model (
  input wire logic core_clk,
  output logic [15:0] io_bus,
  output logic io_write_strobe_n,
  output logic translation_inhibit_n,
  output logic memory_pointer_load_n,
  output logic memory_pointer_step,
  output logic transfer_fault_strobe,
  output logic cpu_full_clock
);
  initial begin
    io_bus = 16'h0000;
    io_write_strobe_n = 1'b1;
    translation_inhibit_n = 1'b1;
    memory_pointer_load_n = 1'b1;
    memory_pointer_step = 1'b0;
    transfer_fault_strobe = 1'b0;
    cpu_full_clock = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic set_pin(input int p, input logic v);
    case (p)
      0: io_write_strobe_n = v;
      1: translation_inhibit_n = v;
      2: memory_pointer_load_n = v;
      3: memory_pointer_step = v;
      4: transfer_fault_strobe = v;
      default: cpu_full_clock = v;
    endcase
  endtask

  // pins 0-2 are active low; six clocks a phase outlasts the pin syncs
  task automatic pulse(input int p, input logic [15:0] d);
    logic act;
    act = (p > 2);
    io_bus = d;
    hold(2);
    set_pin(p, act);
    hold(6);
    set_pin(p, !act);
    hold(6);
    // released bus shows garbage, not the last word
    io_bus = ~d;
  endtask

  task automatic level(input int p, input logic v, input logic [15:0] d);
    io_bus = d;
    hold(1);
    set_pin(p, v);
    hold(7);
  endtask
endmodule

//--- testbench.sv
// self-checking bench for the page map control datapath
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic system_reset_line_n = 1'b1;
  logic [3:0] selected_key = 4'h0;
  logic predecode_phase = 1'b0;
  logic error_detected = 1'b0;
  logic external_control_instruction = 1'b0;
  logic [2:0] control_function = 3'h5;
  logic jump_decoded = 1'b0;
  pmcd_pkg::pmcd_entry_t map_entry = 13'h0000;
  logic [15:0] logical_address = 16'h0000;
  logic memory_request = 1'b0;
  logic instruction_fetch = 1'b0;
  logic write_access = 1'b0;
  logic [17:0] expansion_data_1 = 18'h0a5a1;
  logic [17:0] expansion_data_2 = 18'h15a52;
  logic [17:0] expansion_data_3 = 18'h2f0f3;
  logic data_driver_enable = 1'b0;
  logic [15:0] io_bus;
  logic io_write_strobe_n, translation_inhibit_n, memory_pointer_load_n;
  logic memory_pointer_step, transfer_fault_strobe, cpu_full_clock;
  logic [9:0] map_entry_pointer;
  logic [1:0] read_source_select;
  logic transfer_outbound, transfer_inbound;
  logic [15:0] transfer_memory_pointer, io_read_data;
  logic translation_active, user_control, executive_control, protection_on;
  pmcd_pkg::pmcd_access_t page_access;
  logic access_refused, unmapped_strobe, page_dirty_bit, page_used_bit;
  logic [15:0] expansion_address_1, expansion_address_2, expansion_address_3;
  logic [6:0] port_page;
  logic mainframe_request;
  logic [17:0] memory_data;
  int fails = 0;
  int n_tests = 0;

  pmcd_core u_pmcd_core (.*);
  pmcd_cpu_model u_pmcd_cpu_model (.*);

  always #12.5 core_clk = ~core_clk;

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string n, input logic [17:0] s,
                     input logic [17:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic code(input logic [2:0] f, input logic j);
    external_control_instruction = 1'b1;
    control_function = f;
    step(1);
    external_control_instruction = 1'b0;
    jump_decoded = j;
    step(1);
    jump_decoded = 1'b0;
    step(4);
  endtask

  task automatic rd(input logic [1:0] s);
    // select field sits at bus bits 11:10, direction bit 12 left low
    u_pmcd_cpu_model.pulse(0, {4'h0, s, 10'h000});
    step(2);
  endtask

  task automatic t_reset;
    chk("active", translation_active, 1'b0);
    chk("user", user_control, 1'b0);
    chk("mem_data", memory_data, 18'h3ffff);
    $display("t_reset finished");
  endtask

  task automatic t_map;
    u_pmcd_cpu_model.pulse(0, 16'h17fe);
    chk("map_ptr", map_entry_pointer, 10'h3fe);
    chk("src_sel", read_source_select, 2'h1);
    chk("outbound", transfer_outbound, 1'b0);
    u_pmcd_cpu_model.pulse(1, 16'h0000);
    chk("map_ptr", map_entry_pointer, 10'h3ff);
    u_pmcd_cpu_model.pulse(1, 16'h0000);
    chk("map_ptr", map_entry_pointer, 10'h000);
    code(3'h3, 1'b0);
    chk("outbound", transfer_outbound, 1'b1);
    chk("inbound", transfer_inbound, 1'b0);
    code(3'h4, 1'b0);
    chk("outbound", transfer_outbound, 1'b0);
    u_pmcd_cpu_model.pulse(0, 16'h0800);
    chk("src_sel", read_source_select, 2'h2);
    code(3'h3, 1'b0);
    chk("inbound", transfer_inbound, 1'b1);
    code(3'h4, 1'b0);
    chk("inbound", transfer_inbound, 1'b0);
    $display("t_map finished");
  endtask

  task automatic t_mem;
    u_pmcd_cpu_model.pulse(2, 16'hfffe);
    chk("mem_ptr", transfer_memory_pointer, 16'hfffe);
    u_pmcd_cpu_model.pulse(3, 16'h0000);
    chk("mem_ptr", transfer_memory_pointer, 16'hffff);
    u_pmcd_cpu_model.pulse(3, 16'h0000);
    chk("mem_ptr", transfer_memory_pointer, 16'h0000);
    // a step strobe while the clock enable is low must not count
    ce = 1'b0;
    u_pmcd_cpu_model.pulse(3, 16'h0000);
    ce = 1'b1;
    step(6);
    chk("mem_ptr", transfer_memory_pointer, 16'h0000);
    $display("t_mem finished");
  endtask

  task automatic t_modes;
    jump_decoded = 1'b1;
    step(1);
    jump_decoded = 1'b0;
    step(3);
    chk("active", translation_active, 1'b0);
    code(3'h1, 1'b1);
    chk("active", translation_active, 1'b1);
    chk("exec", executive_control, 1'b1);
    code(3'h2, 1'b1);
    chk("user", user_control, 1'b1);
    chk("exec", executive_control, 1'b0);
    code(3'h1, 1'b1);
    chk("exec", executive_control, 1'b1);
    code(3'h0, 1'b1);
    chk("active", translation_active, 1'b0);
    chk("user", user_control, 1'b0);
    code(3'h1, 1'b1);
    chk("user", user_control, 1'b0);
    chk("exec", executive_control, 1'b1);
    system_reset_line_n = 1'b0;
    step(8);
    chk("active", translation_active, 1'b0);
    system_reset_line_n = 1'b1;
    step(6);
    $display("t_modes finished");
  endtask

  task automatic t_paths;
    logic [17:0] exp_d;
    map_entry = {2'b00, 2'h1, 2'h0, 7'h55};
    logical_address = 16'h81ab;
    memory_request = 1'b1;
    step(3);
    chk("port_page", port_page, 7'h40);
    chk("mainframe", mainframe_request, 1'b1);
    code(3'h1, 1'b1);
    chk("port_page", port_page, 7'h55);
    chk("exp_addr1", expansion_address_1, 16'habab);
    chk("exp_addr2", expansion_address_2, 16'habab);
    chk("exp_addr3", expansion_address_3, 16'habab);
    data_driver_enable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      map_entry.mem_sel = i[1:0];
      exp_d = (i == 1) ? expansion_data_1 : (i == 2) ? expansion_data_2 :
              (i == 3) ? expansion_data_3 : 18'h3ffff;
      step(3);
      chk("mem_data", memory_data, exp_d);
    end
    data_driver_enable = 1'b0;
    step(3);
    chk("mem_data", memory_data, 18'h3ffff);
    chk("mainframe", mainframe_request, 1'b0);
    $display("t_paths finished");
  endtask

  task automatic t_access;
    code(3'h6, 1'b0);
    chk("prot_on", protection_on, 1'b1);
    logical_address = 16'h4321;
    for (int i = 0; i < 4; i++) begin
      map_entry.access = i[1:0];
      instruction_fetch = 1'b1;
      write_access = 1'b0;
      step(3);
      chk("access", page_access, {i == 0, i == 1, i == 2, i == 3});
      chk("unmap_stb", unmapped_strobe, i == 0);
      chk("refuse_if", access_refused, (i == 0) || (i == 2));
      instruction_fetch = 1'b0;
      write_access = 1'b1;
      step(3);
      chk("refuse_wr", access_refused, (i == 0) || (i == 3));
    end
    write_access = 1'b0;
    map_entry.access = 2'h1;
    logical_address = 16'h0777;
    step(3);
    rd(2'h2);
    chk("unmap_addr", io_read_data, 16'h4321);
    $display("t_access finished");
  endtask

  task automatic t_fault;
    selected_key = 4'h9;
    u_pmcd_cpu_model.pulse(4, 16'h0000);
    selected_key = 4'h2;
    rd(2'h0);
    chk("fault_key", io_read_data[3:0], 4'h9);
    $display("t_fault finished");
  endtask

  task automatic t_iaddr;
    predecode_phase = 1'b1;
    logical_address = 16'h1235;
    u_pmcd_cpu_model.pulse(5, 16'h0000);
    rd(2'h1);
    chk("instr_addr", io_read_data, 16'h1235);
    error_detected = 1'b1;
    step(1);
    error_detected = 1'b0;
    logical_address = 16'h2000;
    u_pmcd_cpu_model.pulse(5, 16'h0000);
    rd(2'h1);
    chk("instr_addr", io_read_data, 16'h1235);
    code(3'h6, 1'b0);
    u_pmcd_cpu_model.pulse(5, 16'h0000);
    predecode_phase = 1'b0;
    logical_address = 16'h3000;
    u_pmcd_cpu_model.pulse(5, 16'h0000);
    rd(2'h1);
    chk("instr_addr", io_read_data, 16'h2000);
    code(3'h7, 1'b0);
    chk("prot_on", protection_on, 1'b0);
    $display("t_iaddr finished");
  endtask

  task automatic t_swap;
    u_pmcd_cpu_model.pulse(0, 16'h1000);
    code(3'h3, 1'b0);
    u_pmcd_cpu_model.level(1, 1'b0, 16'h0800);
    chk("dirty", page_dirty_bit, 1'b1);
    chk("used", page_used_bit, 1'b1);
    u_pmcd_cpu_model.level(1, 1'b0, 16'h1000);
    chk("dirty", page_dirty_bit, 1'b0);
    chk("used", page_used_bit, 1'b0);
    u_pmcd_cpu_model.level(1, 1'b1, 16'h1800);
    chk("dirty", page_dirty_bit, 1'b0);
    chk("used", page_used_bit, 1'b1);
    code(3'h4, 1'b0);
    u_pmcd_cpu_model.pulse(0, 16'h0000);
    code(3'h3, 1'b0);
    u_pmcd_cpu_model.level(1, 1'b0, 16'h0000);
    chk("used", page_used_bit, 1'b0);
    u_pmcd_cpu_model.level(1, 1'b1, 16'h0000);
    code(3'h4, 1'b0);
    $display("t_swap finished");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    step(6);
    t_reset;
    t_map;
    t_mem;
    t_modes;
    t_paths;
    t_access;
    t_fault;
    t_iaddr;
    t_swap;
    report_and_stop;
  end

  // whole run is a few hundred clocks; twenty thousand means a hang
  initial begin
    #500000;
    fails++;
    report_and_stop;
  end
endmodule
